/* File: inc/rpg_pkg.sv */
// package: register map, field layout and widths of the rail status bank
package rpg_pkg;
    localparam int RPG_AW = 8; // register address width
    localparam int RPG_DW = 8; // register data width
    localparam logic [7:0] RPG_OFS_PG_B = 8'hB1; // power_good_status_b
    localparam logic [7:0] RPG_OFS_FLT_A = 8'hB2; // rail_fault_status_a
    localparam logic [7:0] RPG_OFS_FLT_B = 8'hB3; // rail_fault_status_b
    localparam logic [7:0] RPG_RST_VAL = 8'h00; // reset value of all three registers
    localparam int RPG_PG_B_BITS = 6; // live bits of power_good_status_b
    localparam int RPG_FLT_A_BITS = 8; // live bits of rail_fault_status_a
    localparam int RPG_FLT_B_BITS = 5; // live bits of rail_fault_status_b
    // power_good_status_b / rail_fault_status_b bit positions
    localparam int RPG_BIT_FIXED_5V = 5;
    localparam int RPG_BIT_AUX_ONE = 4;
    localparam int RPG_BIT_TERM = 3;
    localparam int RPG_BIT_SW_B_TWO = 2;
    localparam int RPG_BIT_SW_B_ONE = 1;
    localparam int RPG_BIT_AUX_THREE = 0;
    // rail_fault_status_a bit positions
    localparam int RPG_BIT_AUX_TWO = 7;
    localparam int RPG_BIT_SW_A_ONE = 6;
    localparam int RPG_BIT_STEPDOWN_LO = 0; // stepdown one .. six at bits 0..5
endpackage

/* File: hdl/rpg_w1c_flag.sv */
// one sticky fault flag: set by a loss-of-regulation pulse, cleared by write-one
`timescale 1ns/1ps
module rpg_w1c_flag (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic set_i, // fault event, same clock domain
    input wire logic clr_i, // write-one strobe for this bit
    output logic flag_o
);
    typedef struct packed {
        logic flag; // sticky flag
    } rpg_flag_t;
    rpg_flag_t st_r;
    rpg_flag_t st_nxt;

    // set beats clear so a fault in the clearing cycle is never lost
    always_comb begin
        st_nxt = st_r;
        if (set_i) begin
            st_nxt.flag = 1'b1;
        end else if (clr_i) begin
            st_nxt.flag = 1'b0;
        end
    end

    // synchronous active-low reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag_o = st_r.flag;

    // a fault always lands, even against a clear in the same cycle
    a_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
        set_i |=> flag_o) else $error("flag not set after fault");
    a_hold_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (flag_o && !clr_i) |=> flag_o) else $error("flag dropped without clear");
endmodule

/* File: hdl/rpg_status_bank.sv */
// rail power-good and sticky fault status register bank
`timescale 1ns/1ps
// What this block does
// - power-good bits mirror rail range, reset 0
// - second power-good register bit mapping 5..0
// - power-good register at B1h, resets zero
// - fault flags set on loss, host W1C
// - first fault register bit mapping 7..0
// - second fault register bits 4..0, 7-5 zero
// - fault registers at B2h, B3h, reset zero
module rpg_status_bank
    import rpg_pkg::*;
(
    input wire logic ref_clk, // 25 MHz device clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic fixed_5v_in_range, // rail range levels from analog comparators
    input wire logic aux_one_in_range,
    input wire logic termination_in_range,
    input wire logic switch_b_two_in_range,
    input wire logic switch_b_one_in_range,
    input wire logic aux_three_in_range,
    input wire logic [RPG_FLT_A_BITS-1:0] fault_a_in, // loss levels, bank a order
    input wire logic [RPG_FLT_B_BITS-1:0] fault_b_in, // loss levels, bank b order
    input wire logic reg_wr, // register write strobe from serial interface
    input wire logic reg_rd, // register read strobe
    input wire logic [RPG_AW-1:0] reg_addr, // register offset
    input wire logic [RPG_DW-1:0] reg_wdata, // write data
    output logic [RPG_DW-1:0] reg_rdata, // read data, one cycle after reg_rd
    output logic reg_rvalid // read data valid pulse
);
    // bank a flags sit in the low bits, bank b flags right above them
    localparam int NLIVE = RPG_FLT_A_BITS + RPG_FLT_B_BITS; // all fault flags

    // all state of this module
    typedef struct packed {
        logic [RPG_PG_B_BITS-1:0] pg_s1; // synchroniser first stage
        logic [RPG_PG_B_BITS-1:0] pg_s2; // synchronised, also register value
        logic [NLIVE-1:0] flt_s1; // fault synchroniser first stage
        logic [NLIVE-1:0] flt_s2; // fault synchroniser second stage
        logic [NLIVE-1:0] flt_d; // previous level for edge detect
        logic [RPG_DW-1:0] rdata; // read data
        logic rvalid; // read data valid
    } rpg_state_t;
    rpg_state_t st_r;
    rpg_state_t st_nxt;

    logic [RPG_PG_B_BITS-1:0] pg_raw; // raw range levels in register order
    logic [NLIVE-1:0] flt_rise; // a rail just lost regulation
    logic [NLIVE-1:0] flt_clr; // write-one clears, per flag
    logic [NLIVE-1:0] flt_q; // sticky flags, bank a low then bank b
    logic wr_a; // write to first fault register
    logic wr_b; // write to second fault register

    // range levels placed at their register bit positions
    always_comb begin
        pg_raw = '0;
        pg_raw[RPG_BIT_FIXED_5V] = fixed_5v_in_range;
        pg_raw[RPG_BIT_AUX_ONE] = aux_one_in_range;
        pg_raw[RPG_BIT_TERM] = termination_in_range;
        pg_raw[RPG_BIT_SW_B_TWO] = switch_b_two_in_range;
        pg_raw[RPG_BIT_SW_B_ONE] = switch_b_one_in_range;
        pg_raw[RPG_BIT_AUX_THREE] = aux_three_in_range;
    end

    // only the two fault offsets take writes; writes to B1h fall through unused
    assign wr_a = reg_wr && (reg_addr == RPG_OFS_FLT_A);
    assign wr_b = reg_wr && (reg_addr == RPG_OFS_FLT_B);
    // only live bits can clear; reserved write bits are dropped
    assign flt_clr = {reg_wdata[RPG_FLT_B_BITS-1:0] & {RPG_FLT_B_BITS{wr_b}},
                      reg_wdata[RPG_FLT_A_BITS-1:0] & {RPG_FLT_A_BITS{wr_a}}};
    // a fault is the edge into loss, so a steady loss re-flags only after recovery
    assign flt_rise = st_r.flt_s2 & ~st_r.flt_d;

    // one sticky flag per rail
    genvar gi;
    generate
        for (gi = 0; gi < NLIVE; gi++) begin : g_flag
            rpg_w1c_flag u_flag (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .set_i(flt_rise[gi]),
                .clr_i(flt_clr[gi]),
                .flag_o(flt_q[gi])
            );
        end
    endgenerate

    // next state: synchronisers, edge history, read mux
    always_comb begin
        st_nxt = st_r;
        st_nxt.pg_s1 = pg_raw;
        st_nxt.pg_s2 = st_r.pg_s1;
        // loss levels come from the analog side, so they get two flops too
        st_nxt.flt_s1 = {fault_b_in, fault_a_in};
        st_nxt.flt_s2 = st_r.flt_s1;
        st_nxt.flt_d = st_r.flt_s2;
        st_nxt.rvalid = reg_rd;
        st_nxt.rdata = '0;
        // status is taken as it stands at the strobe edge; a read has no side effect
        if (reg_rd) begin
            unique case (reg_addr)
                RPG_OFS_PG_B: begin
                    st_nxt.rdata = {{(RPG_DW-RPG_PG_B_BITS){1'b0}}, st_r.pg_s2};
                end
                RPG_OFS_FLT_A: begin
                    st_nxt.rdata = flt_q[RPG_FLT_A_BITS-1:0];
                end
                RPG_OFS_FLT_B: begin
                    st_nxt.rdata = {{(RPG_DW-RPG_FLT_B_BITS){1'b0}}, flt_q[NLIVE-1:RPG_FLT_A_BITS]};
                end
                default: begin
                    st_nxt.rdata = RPG_RST_VAL; // unmapped offsets read zero
                end
            endcase
        end
    end

    // synchronous reset clears every status bit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs come straight from the state register, never from the read mux
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;

    // power-good readback is the synchronised status of the strobe edge
    a_pg_tracks: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == RPG_OFS_PG_B |=> reg_rdata[RPG_PG_B_BITS-1:0] == $past(st_r.pg_s2))
        else $error("power-good readback wrong");

    // pins two edges back, in register order, give the status
    // skipped until two edges out of reset, while the flops still hold zero
    a_pg_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(rst_n) && $past(rst_n, 2) |-> st_r.pg_s2 == $past({fixed_5v_in_range, aux_one_in_range,
        termination_in_range, switch_b_two_in_range, switch_b_one_in_range, aux_three_in_range}, 2))
        else $error("power-good map wrong");

    // reserved top bits of the power-good register read zero
    a_pg_rsv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(reg_rd) && $past(reg_addr) == RPG_OFS_PG_B |-> reg_rdata[7:6] == 2'b00)
        else $error("power-good reserved nonzero");

    // a detected edge on flag 0 always lands in that flag
    a_flt_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        flt_rise[0] |=> flt_q[0])
        else $error("fault not captured");

    // a pin going into loss is flagged three edges later, whatever the host writes
    a_loss_a_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(fault_a_in[RPG_BIT_AUX_TWO]) |-> ##3 flt_q[RPG_BIT_AUX_TWO])
        else $error("aux two fault not flagged");

    // same for bank b, whose flags sit above bank a
    a_loss_b_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(fault_b_in[RPG_BIT_SW_B_TWO]) |-> ##3 flt_q[RPG_FLT_A_BITS+RPG_BIT_SW_B_TWO])
        else $error("switch b two fault not flagged");

    // a flag only rises when its pin was in loss three edges before
    a_flag_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(flt_q[RPG_BIT_AUX_TWO]) |-> $past(fault_a_in[RPG_BIT_AUX_TWO], 3))
        else $error("flag set without a fault");

    // first fault register reads back the flags of the strobe edge
    a_flt_a_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == RPG_OFS_FLT_A |=> reg_rdata == $past(flt_q[7:0]))
        else $error("fault a readback wrong");

    // second fault register reads back the bank b flags in its low bits
    a_flt_b_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == RPG_OFS_FLT_B
        |=> reg_rdata[RPG_FLT_B_BITS-1:0] == $past(flt_q[NLIVE-1:RPG_FLT_A_BITS]))
        else $error("fault b readback wrong");

    // reserved top bits of the second fault register read zero
    a_flt_b_rsv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr == RPG_OFS_FLT_B |=> reg_rdata[7:5] == 3'b000)
        else $error("fault b reserved nonzero");

    // write-one at B3h clears a flag when no new fault meets it
    a_clr_works: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_b && reg_wdata[0] && !flt_rise[RPG_FLT_A_BITS] |=> !flt_q[RPG_FLT_A_BITS])
        else $error("write one did not clear");

    // no set flag of bank a drops where the write carried a zero
    a_zero_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_a |=> ($past(flt_q[RPG_FLT_A_BITS-1:0]) & ~$past(reg_wdata)
        & ~flt_q[RPG_FLT_A_BITS-1:0]) == '0)
        else $error("write zero cleared");

    // offsets outside the bank read as zero
    a_unmapped_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd && reg_addr != RPG_OFS_PG_B && reg_addr != RPG_OFS_FLT_A && reg_addr != RPG_OFS_FLT_B
        |=> reg_rdata == RPG_RST_VAL)
        else $error("unmapped read nonzero");

    // every read strobe is answered by a valid pulse one edge on
    a_read_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_rd |=> reg_rvalid)
        else $error("read not answered");

    // without a strobe the read port stays quiet
    a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_rd |=> !reg_rvalid && reg_rdata == RPG_RST_VAL)
        else $error("read port not idle");

    // reset clears the read port and every flag, no matter what the pins do
    a_rst_zero: assert property (@(posedge ref_clk)
        !rst_n |=> reg_rdata == RPG_RST_VAL && flt_q == '0)
        else $error("reset not zero");

    // main scenarios the bench is meant to reach
    c_read_pg: cover property (@(posedge ref_clk) reg_rd && reg_addr == RPG_OFS_PG_B);
    c_fault_set: cover property (@(posedge ref_clk) |flt_rise);
    c_clear: cover property (@(posedge ref_clk) wr_a && |(flt_q[7:0] & reg_wdata));
    c_race: cover property (@(posedge ref_clk) |(flt_rise & flt_clr));
    c_rsv_write: cover property (@(posedge ref_clk) wr_b && |reg_wdata[RPG_DW-1:RPG_FLT_B_BITS]);
endmodule

/* File: test/rpg_host_model.sv */
// host model: single-byte register writes and reads over the strobe interface
`timescale 1ns/1ps
module rpg_host_model (
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // idle at time zero
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
    end
    // write held for one edge; an idle edge follows so strobes never retoggle in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d; // stale data is not left on the bus
        @(posedge ref_clk);
        #1;
    endtask
    // read: data and valid are taken in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
        v = reg_rvalid;
        @(posedge ref_clk);
        #1;
    endtask
endmodule

/* File: test/tb.sv */
// self-checking bench for the rail status bank
`timescale 1ns/1ps
module tb;
    import rpg_pkg::*;
    logic ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, v;
    logic [5:0] pg; // in-range levels, power-good bit order
    logic [7:0] fa, reg_addr, reg_wdata, reg_rdata, d;
    logic [4:0] fb;
    int failures = 0;
    int n_checks = 0;
    // rows: power-good levels, bank a losses, bank b losses
    logic [18:0] rows [4] = '{{6'h2A, 8'h81, 5'h15}, {6'h15, 8'h7E, 5'h0A}, {6'h3F, 8'hFF, 5'h1F}, 19'h00000};
    rpg_status_bank dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .fixed_5v_in_range(pg[5]), .aux_one_in_range(pg[4]),
        .termination_in_range(pg[3]), .switch_b_two_in_range(pg[2]), .switch_b_one_in_range(pg[1]),
        .aux_three_in_range(pg[0]), .fault_a_in(fa), .fault_b_in(fb), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    rpg_host_model host_u (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read one register, check the valid pulse and the data
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host_u.rd(a, d, v);
        check({7'h00, v}, 8'h01);
        check(d, exp);
    endtask
    // fixed waits only; inputs land 1 ns after the edge
    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        #2000000;
        failures++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        {pg, fa, fb} = 19'h00000;
        waitc(16);
        rst_n = 1'b1;
        rchk(RPG_OFS_PG_B, RPG_RST_VAL);
        rchk(RPG_OFS_FLT_A, RPG_RST_VAL);
        rchk(RPG_OFS_FLT_B, RPG_RST_VAL);
        $display("test reset done");
        // bank a flags must outlive their cause, then both banks clear on write-one
        foreach (rows[i]) begin
            {pg, fa, fb} = rows[i];
            waitc(6);
            rchk(RPG_OFS_PG_B, {2'b00, pg});
            rchk(RPG_OFS_FLT_B, {3'b000, fb});
            {fa, fb} = 13'h0000;
            waitc(6);
            rchk(RPG_OFS_FLT_A, rows[i][12:5]);
            host_u.wr(RPG_OFS_FLT_A, 8'hFF);
            host_u.wr(RPG_OFS_FLT_B, 8'hFF);
            rchk(RPG_OFS_FLT_A, 8'h00);
            rchk(RPG_OFS_FLT_B, 8'h00);
            $display("test row %0d done", i);
        end
        // write zero, reserved bits, read-only and unmapped places
        {pg, fa, fb} = {6'h3F, 8'hA5, 5'h1F};
        waitc(6);
        host_u.wr(RPG_OFS_FLT_A, 8'h00);
        host_u.wr(RPG_OFS_FLT_B, 8'hE1);
        host_u.wr(RPG_OFS_PG_B, 8'h00);
        host_u.wr(8'hB6, 8'hFF);
        rchk(RPG_OFS_FLT_A, 8'hA5);
        rchk(RPG_OFS_FLT_B, 8'h1E);
        rchk(RPG_OFS_PG_B, 8'h3F);
        rchk(8'hB6, 8'h00);
        host_u.wr(RPG_OFS_FLT_A, 8'h81);
        rchk(RPG_OFS_FLT_A, 8'h24);
        $display("test awkward done");
        // reset in mid-run drops sticky flags; causes removed first
        {fa, fb} = 13'h0000;
        rst_n = 1'b0;
        waitc(3);
        rst_n = 1'b1;
        rchk(RPG_OFS_PG_B, 8'h00);
        rchk(RPG_OFS_FLT_A, 8'h00);
        rchk(RPG_OFS_FLT_B, 8'h00);
        $display("test mid-run reset done");
        // fault edge and write-one land on one edge: the fault must win
        fb = 5'h01;
        waitc(2);
        host_u.wr(RPG_OFS_FLT_B, 8'h01);
        rchk(RPG_OFS_FLT_B, 8'h01);
        // a steady loss does not flag again once cleared
        host_u.wr(RPG_OFS_FLT_B, 8'h01);
        rchk(RPG_OFS_FLT_B, 8'h00);
        rchk(RPG_OFS_PG_B, 8'h3F);
        $display("test race done");
        tally_and_finish();
    end
endmodule
